// [hw/config_word_code_protect.v]
// serial program port, configuration word decode and code protection
// assumes pins are asynchronous and the serial clock is far slower than clk
// Summary of operation
// - config bits read 1 erased, 0 programmed; programming only clears.
// - read-only part identification word sits at 2006h.
// - configuration word sits at 2007h, reached by address increments.
// - 4K parts: code 11 no protection, 00 protects 0000h-0FFFh.
// - 8K parts: 10 top 1F00h, 01 upper half, 00 all, 11 none.
// - 2K parts: code 00 protects 0000h-07FFh, 11 none.
// - bit 10 reads as 1; bit 11 written 1 by programmer.
// - bit 9 set allows on-chip self-writes of unprotected memory.
// - bit 8 low protects the data EEPROM.
// - bit 7 gives the low-voltage pin its programming function.
// - bit 6 enables brown-out reset, which forces power-up timer on.
// - bit 3 low enables the power-up timer.
// - bit 2 enables the watchdog.
// - bits 1-0 select RC, HS, XT or LP oscillator.
// - protected program reads give zero; IDs and config read true.
// - protection blocks program and data writes, not IDs or config.
// - protection clear erases all program and data memory.
// - load configuration sets the address to 2000h and takes a word.
// - increment address advances the address by one.
// - bits go LSB first, driven on rising, sampled on falling edge.
`include "cfg_protect_map.vh"
module config_word_code_protect #(
  parameter PART_KWORDS = 8,
  parameter [13:0] PROG_DEPTH = 14'h2000,
  parameter PROG_AW = 13,
  parameter [13:0] DATA_DEPTH = 14'h0040,
  parameter DATA_AW = 6,
  parameter [8:0] PART_CODE = 9'h0A5,
  parameter [4:0] PART_REV = 5'h03
) (
  input wire clk,
  input wire srst,
  input wire prog_clk_pin,
  input wire prog_data_in,
  output reg prog_data_out,
  output reg prog_data_oe_n,
  input wire master_clear_pin,
  input wire low_voltage_entry_pin,
  output reg code_protect_active,
  output reg data_eeprom_protect_active,
  output reg self_write_enable,
  output reg low_voltage_prog_enable,
  output reg brownout_reset_enable,
  output reg power_up_timer_enable,
  output reg watchdog_enable,
  output reg [1:0] osc_select,
  output reg erase_busy
);
  // ****************************************
  // phases and kinds
  // ****************************************
  localparam [1:0] PH_CMD = 2'h0;
  localparam [1:0] PH_LOAD = 2'h1;
  localparam [1:0] PH_READ = 2'h2;
  localparam [1:0] SEQ_IDLE = 2'h0;
  localparam [1:0] SEQ_ONE = 2'h1;
  localparam [1:0] SEQ_TWO = 2'h2;
  localparam [13:0] PROG_LAST = PROG_DEPTH - 14'h0001;
  localparam [13:0] DATA_LAST = DATA_DEPTH - 14'h0001;

  // ****************************************
  // protection decode
  // ****************************************
  // decoder for reads only; writes use prog_locked, which blocks every program and data address for any code but 11
  function prot_hit;
    input [13:0] a;
    input [1:0] cp;
    begin
      prot_hit = 1'b0;
      if (a < `CFG_BASE)
      begin
        case (PART_KWORDS)
          2: prot_hit = (cp == `CP_ALL) && (a <= `PROT_2K_LAST);
          4: prot_hit = (cp == `CP_ALL) && (a <= `PROT_4K_LAST);
          default:
          begin
            case (cp)
              `CP_ALL: prot_hit = (a <= `PROT_8K_LAST);
              `CP_HALF: prot_hit = (a >= `PROT_8K_HALF) &&
                (a <= `PROT_8K_LAST);
              `CP_TOP: prot_hit = (a >= `PROT_8K_TOP) &&
                (a <= `PROT_8K_LAST);
              default: prot_hit = 1'b0;
            endcase
          end
        endcase
      end
    end
  endfunction

  // small parts honour only 00 and 11
  function [1:0] cp_decode;
    input [13:0] w;
    begin
      if (w[`CP_B_HI:`CP_B_LO] != w[`CP_A_HI:`CP_A_LO])
        cp_decode = `CP_NONE;
      else if ((PART_KWORDS != 8) && (w[`CP_A_HI:`CP_A_LO] != `CP_ALL))
        cp_decode = `CP_NONE;
      else
        cp_decode = w[`CP_A_HI:`CP_A_LO];
    end
  endfunction

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  wire [3:0] pins_s;
  reg ck_d;
  reg mode_d;
  pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .pin_in({low_voltage_entry_pin, master_clear_pin, prog_data_in,
      prog_clk_pin}),
    .pin_out(pins_s)
  );
  wire ck_s = pins_s[0];
  wire din_s = pins_s[1];
  wire mode_on = pins_s[2] | (low_voltage_prog_enable & pins_s[3]);
  wire ck_rise = ck_s & ~ck_d;
  wire ck_fall = ~ck_s & ck_d;
  wire mode_fall = mode_d & ~mode_on;

  // ****************************************
  // state
  // ****************************************
  reg [1:0] phase;
  reg [4:0] bit_cnt;
  reg [15:0] in_sr;
  reg [13:0] out_sr;
  reg [13:0] pc;
  reg [13:0] ld_word;
  reg ld_data_kind;
  reg [1:0] clr_seq;
  reg bulk_prog_arm;
  reg bulk_data_arm;
  reg [13:0] cfg_word;
  reg [13:0] id_word [0:3];
  reg [1:0] cp_eff;
  reg relatch;
  reg prog_we;
  reg data_we;
  reg erase_prog;
  reg erase_data;
  reg [13:0] erase_cnt;
  integer k;

  wire [5:0] cmd_now = {din_s, in_sr[15:11]};
  wire prog_locked = (cp_eff != `CP_NONE);
  wire [13:0] erase_last = erase_prog ? PROG_LAST : DATA_LAST;

  // ****************************************
  // memories
  // ****************************************
  wire [13:0] prog_rd;
  wire [7:0] data_rd;
  nv_array #(
    .WIDTH(14),
    .AW(PROG_AW),
    .DEPTH(PROG_DEPTH)
  ) u_prog (
    .clk(clk),
    .wr_en(prog_we | erase_prog),
    .addr(erase_prog ? erase_cnt[PROG_AW-1:0] : pc[PROG_AW-1:0]),
    .wr_data(erase_prog ? `CFG_ERASED : ld_word),
    .rd_data(prog_rd)
  );
  // address wraps: only the low bits reach the data array
  nv_array #(
    .WIDTH(8),
    .AW(DATA_AW),
    .DEPTH(DATA_DEPTH)
  ) u_data (
    .clk(clk),
    .wr_en(data_we | erase_data),
    .addr(erase_data ? erase_cnt[DATA_AW-1:0] : pc[DATA_AW-1:0]),
    .wr_data(erase_data ? 8'hFF : ld_word[7:0]),
    .rd_data(data_rd)
  );

  // ****************************************
  // read value selection
  // ****************************************
  reg [13:0] cfg_space_val;
  always @*
  begin
    cfg_space_val = `CFG_ERASED;
    if (pc <= `ID_LAST)
      cfg_space_val = id_word[pc[1:0]];
    else if (pc == `PART_ID_ADDR)
      cfg_space_val = {PART_CODE, PART_REV};
    else if (pc == `CONFIG_ADDR)
      cfg_space_val = cfg_word | (14'h0001 << `UNIMP_BIT);
  end

  reg [13:0] read_val;
  always @*
  begin
    if (ld_data_kind)
      read_val = data_eeprom_protect_active ? 14'h0000 :
        {6'h00, data_rd};
    else if (pc >= `CFG_BASE)
      read_val = cfg_space_val;
    else if (prot_hit(pc, cp_eff))
      read_val = 14'h0000;
    else
      read_val = prog_rd;
  end

  // ****************************************
  // serial engine
  // ****************************************
  always @(posedge clk)
  begin
    if (srst)
    begin
      ck_d <= 1'b0;
      mode_d <= 1'b0;
      phase <= PH_CMD;
      bit_cnt <= 5'h00;
      in_sr <= 16'h0000;
      out_sr <= 14'h0000;
      pc <= 14'h0000;
      ld_word <= 14'h0000;
      ld_data_kind <= 1'b0;
      clr_seq <= SEQ_IDLE;
      bulk_prog_arm <= 1'b0;
      bulk_data_arm <= 1'b0;
      prog_data_out <= 1'b0;
      prog_data_oe_n <= 1'b1;
      prog_we <= 1'b0;
      data_we <= 1'b0;
      erase_prog <= 1'b0;
      erase_data <= 1'b0;
      erase_cnt <= 14'h0000;
      erase_busy <= 1'b0;
      cfg_word <= `CFG_ERASED;
      for (k = 0; k < 4; k = k + 1)
        id_word[k] <= `CFG_ERASED;
    end
    else
    begin
      ck_d <= ck_s;
      mode_d <= mode_on;
      prog_we <= 1'b0;
      data_we <= 1'b0;
      // erase walks every word; far shorter than the programmer's wait
      if (erase_prog | erase_data)
      begin
        erase_cnt <= erase_cnt + 14'h0001;
        if (erase_cnt == erase_last)
        begin
          erase_prog <= 1'b0;
          erase_data <= 1'b0;
          erase_cnt <= 14'h0000;
        end
      end
      erase_busy <= erase_prog | erase_data;
      if (!mode_on)
      begin
        phase <= PH_CMD;
        bit_cnt <= 5'h00;
        pc <= 14'h0000;
        clr_seq <= SEQ_IDLE;
        bulk_prog_arm <= 1'b0;
        bulk_data_arm <= 1'b0;
        prog_data_oe_n <= 1'b1;
      end
      else
      begin
        case (phase)
          PH_CMD:
          begin
            if (ck_fall)
            begin
              in_sr <= {din_s, in_sr[15:1]};
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == `CMD_BITS - 5'h01)
              begin
                bit_cnt <= 5'h00;
                clr_seq <= SEQ_IDLE;
                if (cmd_now == `CMD_CLR_STEP1 && pc == `CONFIG_ADDR &&
                  (ld_word & `CLR_MASK) == `CLR_MASK)
                  clr_seq <= SEQ_ONE;
                else if (cmd_now == `CMD_CLR_STEP2 && clr_seq == SEQ_ONE)
                  clr_seq <= SEQ_TWO;
                else if (cmd_now == `CMD_BEGIN_ERASE_PROG ||
                  cmd_now == `CMD_BEGIN_PROG_ONLY)
                begin
                  bulk_prog_arm <= 1'b0;
                  bulk_data_arm <= 1'b0;
                  if (erase_busy)
                    bulk_prog_arm <= 1'b0;
                  else if (clr_seq == SEQ_TWO &&
                    cmd_now == `CMD_BEGIN_ERASE_PROG)
                  begin
                    erase_prog <= 1'b1;
                    erase_data <= 1'b1;
                    erase_cnt <= 14'h0000;
                    cfg_word <= `CFG_ERASED;
                    for (k = 0; k < 4; k = k + 1)
                      id_word[k] <= `CFG_ERASED;
                  end
                  else if (bulk_prog_arm)
                  begin
                    if (!prog_locked)
                    begin
                      erase_prog <= 1'b1;
                      erase_cnt <= 14'h0000;
                      if (pc >= `CFG_BASE && pc <= `TEST_LAST)
                        for (k = 0; k < 4; k = k + 1)
                          id_word[k] <= `CFG_ERASED;
                    end
                  end
                  else if (bulk_data_arm)
                  begin
                    if (!prog_locked && !data_eeprom_protect_active)
                    begin
                      erase_data <= 1'b1;
                      erase_cnt <= 14'h0000;
                    end
                  end
                  else if (ld_data_kind)
                    data_we <= !prog_locked &&
                      !data_eeprom_protect_active;
                  else if (pc < `CFG_BASE)
                    prog_we <= !prog_locked;
                  else if (pc <= `ID_LAST)
                    id_word[pc[1:0]] <= ld_word;
                  else if (pc == `CONFIG_ADDR)
                    cfg_word <= (cfg_word & ld_word) |
                      (14'h0001 << `UNIMP_BIT);
                end
                else
                begin
                  case (cmd_now[3:0])
                    `CMD_LOAD_CFG:
                    begin
                      pc <= `CFG_BASE;
                      ld_data_kind <= 1'b0;
                      phase <= PH_LOAD;
                    end
                    `CMD_LOAD_PROG:
                    begin
                      ld_data_kind <= 1'b0;
                      phase <= PH_LOAD;
                    end
                    `CMD_LOAD_DATA:
                    begin
                      ld_data_kind <= 1'b1;
                      phase <= PH_LOAD;
                    end
                    `CMD_READ_PROG:
                    begin
                      ld_data_kind <= 1'b0;
                      phase <= PH_READ;
                    end
                    `CMD_READ_DATA:
                    begin
                      ld_data_kind <= 1'b1;
                      phase <= PH_READ;
                    end
                    `CMD_INC_ADDR: pc <= pc + 14'h0001;
                    `CMD_BULK_PROG: bulk_prog_arm <= 1'b1;
                    `CMD_BULK_DATA: bulk_data_arm <= 1'b1;
                    default: phase <= PH_CMD;
                  endcase
                end
              end
            end
          end
          PH_LOAD:
          begin
            if (ck_fall)
            begin
              in_sr <= {din_s, in_sr[15:1]};
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == `WORD_CLKS - 5'h01)
              begin
                ld_word <= in_sr[15:2];
                bit_cnt <= 5'h00;
                phase <= PH_CMD;
              end
            end
          end
          PH_READ:
          begin
            // the pin turns round only between rise 2 and rise 16
            if (ck_rise && bit_cnt < `WORD_CLKS)
            begin
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == 5'h00)
                out_sr <= read_val;
              else if (bit_cnt == `WORD_CLKS - 5'h01)
                prog_data_oe_n <= 1'b1;
              else
              begin
                prog_data_oe_n <= 1'b0;
                prog_data_out <= out_sr[0];
                out_sr <= {1'b0, out_sr[13:1]};
              end
            end
            else if (ck_fall && bit_cnt == `WORD_CLKS)
            begin
              bit_cnt <= 5'h00;
              phase <= PH_CMD;
            end
          end
          default: phase <= PH_CMD;
        endcase
      end
    end
  end

  // ****************************************
  // configuration field latch
  // ****************************************
  // fields change only at reset or leaving program mode, never mid-run
  always @(posedge clk)
  begin
    if (srst)
    begin
      relatch <= 1'b1;
      cp_eff <= `CP_NONE;
      code_protect_active <= 1'b0;
      data_eeprom_protect_active <= 1'b0;
      self_write_enable <= 1'b1;
      low_voltage_prog_enable <= 1'b1;
      brownout_reset_enable <= 1'b1;
      power_up_timer_enable <= 1'b1;
      watchdog_enable <= 1'b1;
      osc_select <= 2'h3;
    end
    else
    begin
      relatch <= mode_fall;
      if (relatch)
      begin
        cp_eff <= cp_decode(cfg_word);
        code_protect_active <= cp_decode(cfg_word) != `CP_NONE;
        data_eeprom_protect_active <= ~cfg_word[`CPD_BIT];
        self_write_enable <= cfg_word[`WRT_BIT];
        low_voltage_prog_enable <= cfg_word[`LVP_BIT];
        brownout_reset_enable <= cfg_word[`BOR_BIT];
        power_up_timer_enable <= ~cfg_word[`POWER_UP_TIMER_OFF_BIT] |
          cfg_word[`BOR_BIT];
        watchdog_enable <= cfg_word[`WDT_BIT];
        osc_select <= cfg_word[`OSC_HI:`OSC_LO];
      end
    end
  end
endmodule // config_word_code_protect

// [hw/cfg_protect_map.vh]
// constants for the configuration word and code-protect block
// assumes a 14-bit word serial program port and 14-bit address space
`ifndef CFG_PROTECT_MAP_VH
`define CFG_PROTECT_MAP_VH
// ****************************************
// serial commands
// ****************************************
`define CMD_BITS 5'h06
`define WORD_CLKS 5'h10
`define CMD_LOAD_CFG 4'h0
`define CMD_LOAD_PROG 4'h2
`define CMD_LOAD_DATA 4'h3
`define CMD_READ_PROG 4'h4
`define CMD_READ_DATA 4'h5
`define CMD_INC_ADDR 4'h6
`define CMD_BULK_PROG 4'h9
`define CMD_BULK_DATA 4'hB
`define CMD_BEGIN_ERASE_PROG 6'h08
`define CMD_BEGIN_PROG_ONLY 6'h18
`define CMD_CLR_STEP1 6'h01
`define CMD_CLR_STEP2 6'h07
// ****************************************
// configuration space
// ****************************************
`define CFG_BASE 14'h2000
`define ID_LAST 14'h2003
`define PART_ID_ADDR 14'h2006
`define CONFIG_ADDR 14'h2007
`define TEST_LAST 14'h200F
`define CFG_ERASED 14'h3FFF
`define CLR_MASK 14'h3FF0
// ****************************************
// configuration word fields
// ****************************************
`define CP_B_HI 13
`define CP_B_LO 12
`define RESERVED_ONE_BIT_BIT 11
`define UNIMP_BIT 10
`define WRT_BIT 9
`define CPD_BIT 8
`define LVP_BIT 7
`define BOR_BIT 6
`define CP_A_HI 5
`define CP_A_LO 4
`define POWER_UP_TIMER_OFF_BIT 3
`define WDT_BIT 2
`define OSC_HI 1
`define OSC_LO 0
`define CP_NONE 2'h3
`define CP_TOP 2'h2
`define CP_HALF 2'h1
`define CP_ALL 2'h0
// ****************************************
// protected ranges
// ****************************************
`define PROT_2K_LAST 14'h07FF
`define PROT_4K_LAST 14'h0FFF
`define PROT_8K_TOP 14'h1F00
`define PROT_8K_HALF 14'h1000
`define PROT_8K_LAST 14'h1FFF
`endif

// [hw/pin_sync.v]
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the clk domain
module pin_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk)
      begin
        if (srst)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign pin_out[i] = sync_reg;
    end
  endgenerate
endmodule // pin_sync

// [hw/nv_array.v]
// single-port word array with registered read data
// assumes contents are undefined until written or erased
module nv_array #(
  parameter WIDTH = 14,
  parameter AW = 13,
  parameter DEPTH = 8192
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge clk)
  begin
    if (wr_en)
      mem[addr] <= wr_data;
    rd_data <= mem[addr];
  end
endmodule // nv_array

// [dv/config_word_code_protect_assertions.sv]
// port checker for the configuration word and code-protect block
// assumes it is bound to the top module; one clk domain, srst synchronous
module config_word_code_protect_assertions
(
  input wire clk,
  input wire srst,
  input wire prog_clk_pin,
  input wire prog_data_out,
  input wire prog_data_oe_n,
  input wire master_clear_pin,
  input wire low_voltage_entry_pin,
  input wire code_protect_active,
  input wire data_eeprom_protect_active,
  input wire brownout_reset_enable,
  input wire power_up_timer_enable,
  input wire watchdog_enable,
  input wire [1:0] osc_select,
  input wire erase_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // erase length counter
  // ****************************************
  int busy_run;
  always @(posedge clk)
  begin
    if (srst || !erase_busy)
      busy_run <= 0;
    else
      busy_run <= busy_run + 1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // properties
  // ****************************************
  a_brownout_needs_timer:
    assert property (brownout_reset_enable |-> power_up_timer_enable)
    else $error("power-up timer off with brown-out reset on");
  a_erase_span:
    assert property ($fell(erase_busy) |-> busy_run > 8180 && busy_run < 8300)
    else $error("erase walk length wrong");
  a_data_on_rise:
    assert property (!prog_data_oe_n && $changed(prog_data_out)
      |-> $past(prog_clk_pin))
    else $error("read data moved away from a rising clock");
  a_drive_on_rise:
    assert property ($fell(prog_data_oe_n) |-> $past(prog_clk_pin))
    else $error("data pin turned round away from a rising clock");
  a_erased_decode:
    assert property ($fell(srst) |-> osc_select == 2'h3 && watchdog_enable
      && !code_protect_active && !data_eeprom_protect_active
      && brownout_reset_enable)
    else $error("fields not at erased decode after reset");
  a_clear_in_mode:
    assert property ($rose(erase_busy) |-> master_clear_pin && prog_data_oe_n)
    else $error("erase started outside program mode");
  a_fields_on_exit:
    assert property ($changed({code_protect_active, watchdog_enable,
      osc_select}) |-> !$past(master_clear_pin) || $past(srst, 3))
    else $error("fields changed while in program mode");
  a_idle_no_drive:
    assert property (!master_clear_pin && !low_voltage_entry_pin
      && !$past(master_clear_pin, 8) |-> prog_data_oe_n)
    else $error("data pin driven outside program mode");
endmodule // config_word_code_protect_assertions

// [dv/prog_model.sv]
// external programmer model for the serial program port
// assumes clk is the bench clock; pins move just after its falling edge
module prog_model
(
  input wire logic clk,
  input wire logic data_wire,
  output logic prog_clk_pin,
  output logic drv_en,
  output logic drv_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // serial cycles, 200 ns period
  // ****************************************
  initial
  begin
    prog_clk_pin = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // clock stands low between frames
  task automatic bit_cycle(input logic en, input logic b, output logic r);
    prog_clk_pin = 1'b1;
    drv_en = en;
    drv_val = b;
    wait_clk(4);
    r = data_wire;
    prog_clk_pin = 1'b0;
    wait_clk(4);
  endtask
  // 48 clk gap covers the 1 us turn-round
  task automatic send_cmd(input logic [5:0] c);
    logic r;
    for (int i = 0; i < 6; i++)
      bit_cycle(1'b1, c[i], r);
    drv_en = 1'b0;
    wait_clk(48);
  endtask
  task automatic load_word(input logic [5:0] c, input logic [13:0] w);
    logic [15:0] f;
    logic r;
    send_cmd(c);
    f = {1'b0, w, 1'b0};
    for (int i = 0; i < 16; i++)
      bit_cycle(1'b1, f[i], r);
    drv_en = 1'b0;
    wait_clk(48);
  endtask
  task automatic read_word(input logic [5:0] c, output logic [13:0] w);
    logic [15:0] f;
    send_cmd(c);
    for (int i = 0; i < 16; i++)
      bit_cycle(1'b0, 1'b0, f[i]);
    w = f[14:1];
    wait_clk(48);
  endtask
endmodule // prog_model

// [dv/config_word_code_protect_tb.sv]
// self-checking bench for the configuration word and code-protect block
// assumes the checker and prog_model are compiled before this file
`include "cfg_protect_map.vh"
module config_word_code_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // harness
  // ****************************************
  localparam [8:0] CODE = 9'h0A5; // arbitrary value
  localparam [4:0] REV = 5'h03; // arbitrary value
  localparam [5:0] LD_CFG = {2'b00, `CMD_LOAD_CFG};
  localparam [5:0] LD_PROG = {2'b00, `CMD_LOAD_PROG};
  localparam [5:0] RD_PROG = {2'b00, `CMD_READ_PROG};
  localparam [5:0] INC = {2'b00, `CMD_INC_ADDR};
  logic clk, srst, master_clear_pin, low_voltage_entry_pin;
  logic prog_clk_pin, drv_en, drv_val, data_wire, prog_data_out;
  logic prog_data_oe_n, erase_busy, code_protect_active;
  logic data_eeprom_protect_active, self_write_enable;
  logic low_voltage_prog_enable, brownout_reset_enable;
  logic power_up_timer_enable, watchdog_enable;
  logic [1:0] osc_select;
  logic idle_pat = 1'b0;
  int fails = 0;
  int check_count = 0;
  logic [15:0] csum;
  logic [13:0] words [5] = '{14'h3FFF, 14'h08CA, 14'h0FFF, 14'h1F15,
    14'h2D2C};
  // released line wanders so a stale bit never passes for data
  always @(posedge clk) idle_pat <= !idle_pat;
  assign data_wire = !prog_data_oe_n ? prog_data_out :
    (drv_en ? drv_val : idle_pat);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  config_word_code_protect #(.PART_CODE(CODE), .PART_REV(REV)) dut_u
  (
    .clk(clk), .srst(srst), .prog_clk_pin(prog_clk_pin),
    .prog_data_in(data_wire), .prog_data_out(prog_data_out),
    .prog_data_oe_n(prog_data_oe_n), .master_clear_pin(master_clear_pin),
    .low_voltage_entry_pin(low_voltage_entry_pin),
    .code_protect_active(code_protect_active),
    .data_eeprom_protect_active(data_eeprom_protect_active),
    .self_write_enable(self_write_enable),
    .low_voltage_prog_enable(low_voltage_prog_enable),
    .brownout_reset_enable(brownout_reset_enable),
    .power_up_timer_enable(power_up_timer_enable),
    .watchdog_enable(watchdog_enable), .osc_select(osc_select),
    .erase_busy(erase_busy)
  );
  prog_model prog_u
  (
    .clk(clk), .data_wire(data_wire), .prog_clk_pin(prog_clk_pin),
    .drv_en(drv_en), .drv_val(drv_val)
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_fields(input logic [13:0] w);
    logic cp;
    logic [13:0] got, exp;
    cp = (w[13:12] == w[5:4]) && (w[5:4] != `CP_NONE);
    exp = {5'h00, cp, !w[8], w[9], w[7], w[6], !w[3] | w[6], w[2], w[1:0]};
    got = {5'h00, code_protect_active, data_eeprom_protect_active,
      self_write_enable, low_voltage_prog_enable, brownout_reset_enable,
      power_up_timer_enable, watchdog_enable, osc_select};
    check(got, exp);
  endtask
  task automatic set_mode(input logic m);
    master_clear_pin = m;
    prog_u.wait_clk(48);
  endtask
  task automatic read_chk(input logic [13:0] exp);
    logic [13:0] r;
    prog_u.read_word(RD_PROG, r);
    check(r, exp);
    csum += r;
  endtask
  task automatic prog_word(input logic [5:0] c, input logic [13:0] w);
    prog_u.load_word(c, w);
    prog_u.send_cmd(`CMD_BEGIN_ERASE_PROG);
  endtask
  task automatic write_cfg(input logic [13:0] w);
    prog_u.load_word(LD_CFG, w);
    repeat (7) prog_u.send_cmd(INC);
    prog_u.send_cmd(`CMD_BEGIN_ERASE_PROG);
  endtask
  // erase time is scaled, so wait on busy rather than 12 ms
  task automatic clear_protect();
    int n;
    prog_u.load_word(LD_CFG, `CFG_ERASED);
    repeat (7) prog_u.send_cmd(INC);
    prog_u.send_cmd(`CMD_CLR_STEP1);
    prog_u.send_cmd(`CMD_CLR_STEP2);
    prog_u.send_cmd(`CMD_BEGIN_ERASE_PROG);
    check({13'h0000, erase_busy}, 14'h0001);
    n = 0;
    while (erase_busy !== 1'b0 && n < 9000)
    begin
      prog_u.wait_clk(1);
      n++;
    end
    check({13'h0000, erase_busy}, 14'h0000);
    prog_u.send_cmd(`CMD_CLR_STEP1);
    prog_u.send_cmd(`CMD_CLR_STEP2);
  endtask
  task automatic run_word(input logic [13:0] w);
    logic cp, all;
    logic [13:0] keep, r;
    cp = (w[13:12] == w[5:4]) && (w[5:4] != `CP_NONE);
    all = (w[13:12] == w[5:4]) && (w[5:4] == `CP_ALL);
    keep = all ? 14'h0000 : 14'h1234;
    set_mode(1'b1);
    clear_protect();
    set_mode(1'b0);
    set_mode(1'b1);
    read_chk(`CFG_ERASED);
    prog_word(LD_PROG, 14'h1234);
    write_cfg(w);
    read_chk(w | 14'h0400);
    write_cfg(`CFG_ERASED);
    read_chk(w | 14'h0400);
    set_mode(1'b0);
    check_fields(w);
    set_mode(1'b1);
    csum = 16'h0000;
    read_chk(keep);
    prog_word(LD_PROG, 14'h0055);
    read_chk(cp ? keep : 14'h0055);
    prog_word({2'h0, `CMD_LOAD_DATA}, 14'h0055);
    prog_u.read_word({2'h0, `CMD_READ_DATA}, r);
    check(r, !w[8] ? 14'h0000 : (cp ? 14'h00FF : 14'h0055));
    prog_u.load_word(LD_CFG, `CFG_ERASED);
    repeat (6) prog_u.send_cmd(INC);
    read_chk({CODE, REV});
    prog_u.send_cmd(INC);
    read_chk(w | 14'h0400);
    check(csum, keep + (cp ? keep : 14'h0055) + {CODE, REV} +
      (w | 14'h0400));
    set_mode(1'b0);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    srst = 1'b1;
    master_clear_pin = 1'b0;
    low_voltage_entry_pin = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    prog_u.wait_clk(8);
    check_fields(`CFG_ERASED);
    foreach (words[i])
      run_word(words[i]);
    report_and_stop();
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    fails++;
    $display("[ERR] %0t ns timeout", $time);
    report_and_stop();
  end
endmodule // config_word_code_protect_tb
bind config_word_code_protect config_word_code_protect_assertions chk_u
(
  .clk(clk), .srst(srst), .prog_clk_pin(prog_clk_pin),
  .prog_data_out(prog_data_out), .prog_data_oe_n(prog_data_oe_n),
  .master_clear_pin(master_clear_pin),
  .low_voltage_entry_pin(low_voltage_entry_pin),
  .code_protect_active(code_protect_active),
  .data_eeprom_protect_active(data_eeprom_protect_active),
  .brownout_reset_enable(brownout_reset_enable),
  .power_up_timer_enable(power_up_timer_enable),
  .watchdog_enable(watchdog_enable), .osc_select(osc_select),
  .erase_busy(erase_busy)
);
